// ==== include/lif_pkg.sv ====
package lif_pkg;
    localparam int unsigned LIF_NUM_CH       = 12;
    // Register offset is the low nibble; the high nibble selects the channel
    localparam logic [3:0]  LIF_OFS_TX_CTL   = 4'h4;
    localparam logic [3:0]  LIF_OFS_RX_CTL   = 4'h5;
    localparam logic [3:0]  LIF_GRP_LO_LAST  = 4'h5;
    localparam logic [3:0]  LIF_GRP_HI_BASE  = 4'h8;
    localparam logic [3:0]  LIF_GRP_HI_LAST  = 4'hD;
    localparam logic [3:0]  LIF_GRP_LO_COUNT = 4'h6;
    // Transmit control fields
    localparam int unsigned LIF_TX_BIT_BUILDOUT = 0;
    localparam int unsigned LIF_TX_BIT_EDGE     = 1;
    localparam int unsigned LIF_TX_BIT_ALL_ONES = 2;
    localparam int unsigned LIF_TX_BIT_PRBS_ERR = 4;
    localparam int unsigned LIF_TX_BIT_MON_INT  = 5;
    // Receive control fields
    localparam int unsigned LIF_RX_BIT_EQ       = 0;
    localparam int unsigned LIF_RX_BIT_MONITOR  = 1;
    localparam int unsigned LIF_RX_BIT_MUTE     = 2;
    localparam int unsigned LIF_RX_BIT_EDGE     = 3;
    localparam int unsigned LIF_RX_BIT_ANALOG_SIGNAL_LOSS_DETECTOR_DIS = 4;
    localparam int unsigned LIF_RX_BIT_DIGITAL_SIGNAL_LOSS_DETECTOR_DIS = 5;
    // Writable bits; all others are reserved
    localparam logic [7:0]  LIF_TX_CTL_WMASK = 8'h37;
    localparam logic [7:0]  LIF_RX_CTL_WMASK = 8'h3F;
    localparam logic [7:0]  LIF_TX_CTL_RST   = 8'h00;
    localparam logic [7:0]  LIF_RX_CTL_RST   = 8'h00;
    localparam logic [7:0]  LIF_RDATA_RST    = 8'h00;

    // Returns {hit, channel index} for a register address
    function automatic logic [4:0] lif_chan_decode(input logic [7:0] addr);
        logic [3:0] grp;
        grp = addr[7:4];
        if (grp <= LIF_GRP_LO_LAST) begin
            lif_chan_decode = {1'b1, grp};
        end else if (grp >= LIF_GRP_HI_BASE && grp <= LIF_GRP_HI_LAST) begin
            lif_chan_decode = {1'b1,
                grp - (LIF_GRP_HI_BASE - LIF_GRP_LO_COUNT)};
        end else begin
            lif_chan_decode = 5'h00;
        end
    endfunction
endpackage

// ==== include/lif_lane_if.sv ====
`timescale 1ns/100ps
interface lif_lane_if;
    logic send_all_ones;
    logic tx_clock_edge_select;
    logic rx_clock_edge_select;
    logic mute_on_signal_loss;

    modport ctrl (
        output send_all_ones,
        output tx_clock_edge_select,
        output rx_clock_edge_select,
        output mute_on_signal_loss
    );
    modport lane (
        input send_all_ones,
        input tx_clock_edge_select,
        input rx_clock_edge_select,
        input mute_on_signal_loss
    );
endinterface

// ==== design/lif_tx_lane.sv ====
`timescale 1ns/100ps
module lif_tx_lane (
    input  wire logic  lclk,
    input  wire logic  srst,
    lif_lane_if.lane   ctl,
    input  wire logic  tx_positive_rail_in,
    input  wire logic  tx_negative_rail_in,
    output logic       tx_line_pos_out,
    output logic       tx_line_neg_out
);
    import lif_pkg::*;

    typedef struct packed {
        logic [1:0] rst_sy;
        logic [1:0] ao_sy;
        logic [1:0] edge_sy;
        logic       mark_tgl;
        logic       pos;
        logic       neg;
    } lif_tx_s;

    lif_tx_s    q;
    lif_tx_s    next_q;
    logic [1:0] fall_smp;
    logic [1:0] smp;

    // Rails captured on the falling edge of the link clock
    always_ff @(negedge lclk) begin
        fall_smp <= {tx_positive_rail_in, tx_negative_rail_in};
    end

    always_comb begin
        next_q         = q;
        smp            = 2'h0;
        next_q.rst_sy  = {q.rst_sy[0], srst};
        next_q.ao_sy   = {q.ao_sy[0], ctl.send_all_ones};
        next_q.edge_sy = {q.edge_sy[0], ctl.tx_clock_edge_select};
        if (q.edge_sy[1]) begin
            smp = {tx_positive_rail_in, tx_negative_rail_in};
        end else begin
            smp = fall_smp;
        end
        if (q.ao_sy[1]) begin
            // Unframed ones: marks alternate between the rails
            next_q.pos      = ~q.mark_tgl;
            next_q.neg      = q.mark_tgl;
            next_q.mark_tgl = ~q.mark_tgl;
        end else begin
            next_q.pos      = smp[1];
            next_q.neg      = smp[0];
            next_q.mark_tgl = 1'b0;
        end
        if (q.rst_sy[1]) begin
            next_q.ao_sy    = 2'h0;
            next_q.edge_sy  = 2'h0;
            next_q.mark_tgl = 1'b0;
            next_q.pos      = 1'b0;
            next_q.neg      = 1'b0;
        end
    end

    always_ff @(posedge lclk) begin
        q <= next_q;
    end

    assign tx_line_pos_out = q.pos;
    assign tx_line_neg_out = q.neg;
endmodule

// ==== design/lif_rx_lane.sv ====
`timescale 1ns/100ps
module lif_rx_lane (
    input  wire logic  rclk,
    input  wire logic  srst,
    lif_lane_if.lane   ctl,
    input  wire logic  rx_recovered_pos,
    input  wire logic  rx_recovered_neg,
    input  wire logic  rx_signal_loss,
    output logic       rx_pos_out,
    output logic       rx_neg_out
);
    import lif_pkg::*;

    typedef struct packed {
        logic [1:0] rst_sy;
        logic [1:0] edge_sy;
        logic [1:0] mute_sy;
        logic [1:0] los_sy;
        logic [1:0] rise_q;
    } lif_rx_s;

    lif_rx_s    q;
    lif_rx_s    next_q;
    logic [1:0] fall_q;
    logic       blank;

    assign blank = q.rst_sy[1] | (q.mute_sy[1] & q.los_sy[1]);

    always_comb begin
        next_q         = q;
        next_q.rst_sy  = {q.rst_sy[0], srst};
        next_q.edge_sy = {q.edge_sy[0], ctl.rx_clock_edge_select};
        next_q.mute_sy = {q.mute_sy[0], ctl.mute_on_signal_loss};
        next_q.los_sy  = {q.los_sy[0], rx_signal_loss};
        next_q.rise_q  = blank ? 2'h0
                               : {rx_recovered_pos, rx_recovered_neg};
        if (q.rst_sy[1]) begin
            next_q.edge_sy = 2'h0;
            next_q.mute_sy = 2'h0;
            next_q.los_sy  = 2'h0;
        end
    end

    always_ff @(posedge rclk) begin
        q <= next_q;
    end

    // Data launched on the falling edge of the receive clock
    always_ff @(negedge rclk) begin
        fall_q <= blank ? 2'h0 : {rx_recovered_pos, rx_recovered_neg};
    end

    assign rx_pos_out = q.edge_sy[1] ? fall_q[1] : q.rise_q[1];
    assign rx_neg_out = q.edge_sy[1] ? fall_q[0] : q.rise_q[0];
endmodule

// ==== design/lif_ctrl_top.sv ====
// Contract
// - All-ones bit set: send unframed ones
// - All-ones bit clear: forward system data unchanged
// - Edge select 0: sample rails on falling
// - Edge select 1: sample rails on rising
// - Build-out ignored in E3 mode
// - Transmit control at 0xm4 per channel
// - Receive control at 0xm5, bits 7-6 reserved
// - Receive edge select picks output clock edge
`timescale 1ns/100ps
module lif_ctrl_top (
    input  wire logic                          clk,
    input  wire logic                          srst,
    input  wire logic                          cpu_sel,
    input  wire logic                          cpu_wr,
    input  wire logic [7:0]                    cpu_addr,
    input  wire logic [7:0]                    cpu_wdata,
    output logic      [7:0]                    cpu_rdata,
    output logic                               cpu_rvalid,
    input  wire logic [lif_pkg::LIF_NUM_CH-1:0] chan_e3_mode,
    output logic      [lif_pkg::LIF_NUM_CH-1:0] tx_buildout_enable,
    input  wire logic [lif_pkg::LIF_NUM_CH-1:0] tx_line_clock_in,
    input  wire logic [lif_pkg::LIF_NUM_CH-1:0] tx_positive_rail_in,
    input  wire logic [lif_pkg::LIF_NUM_CH-1:0] tx_negative_rail_in,
    output logic      [lif_pkg::LIF_NUM_CH-1:0] tx_line_pos_out,
    output logic      [lif_pkg::LIF_NUM_CH-1:0] tx_line_neg_out,
    input  wire logic [lif_pkg::LIF_NUM_CH-1:0] rx_recovered_clock,
    input  wire logic [lif_pkg::LIF_NUM_CH-1:0] rx_recovered_pos,
    input  wire logic [lif_pkg::LIF_NUM_CH-1:0] rx_recovered_neg,
    input  wire logic [lif_pkg::LIF_NUM_CH-1:0] rx_signal_loss,
    output logic      [lif_pkg::LIF_NUM_CH-1:0] rx_pos_out,
    output logic      [lif_pkg::LIF_NUM_CH-1:0] rx_neg_out
);
    import lif_pkg::*;

    typedef struct packed {
        logic [LIF_NUM_CH-1:0][7:0] tx_ctl;
        logic [LIF_NUM_CH-1:0][7:0] rx_ctl;
        logic [LIF_NUM_CH-1:0]      buildout;
        logic [7:0]                 rdata;
        logic                       rvalid;
    } lif_regs_s;

    lif_regs_s  q;
    lif_regs_s  next_q;
    logic [4:0] dec;
    logic       hit;
    logic [3:0] idx;
    logic       is_tx;
    logic       is_rx;

    always_comb begin
        next_q        = q;
        dec           = lif_chan_decode(cpu_addr);
        hit           = dec[4];
        idx           = dec[3:0];
        is_tx         = hit && (cpu_addr[3:0] == LIF_OFS_TX_CTL);
        is_rx         = hit && (cpu_addr[3:0] == LIF_OFS_RX_CTL);
        next_q.rvalid = 1'b0;
        if (cpu_sel && cpu_wr) begin
            if (is_tx) begin
                next_q.tx_ctl[idx] = cpu_wdata & LIF_TX_CTL_WMASK;
            end
            if (is_rx) begin
                next_q.rx_ctl[idx] = cpu_wdata & LIF_RX_CTL_WMASK;
            end
        end
        if (cpu_sel && !cpu_wr) begin
            next_q.rvalid = 1'b1;
            next_q.rdata  = 8'h00;
            if (is_tx) begin
                next_q.rdata = q.tx_ctl[idx];
            end else if (is_rx) begin
                next_q.rdata = q.rx_ctl[idx];
            end
        end
        for (int i = 0; i < LIF_NUM_CH; i++) begin
            // Build-out only drives the shaper outside E3 mode
            next_q.buildout[i] = q.tx_ctl[i][LIF_TX_BIT_BUILDOUT]
                                 & ~chan_e3_mode[i];
        end
        if (srst) begin
            for (int i = 0; i < LIF_NUM_CH; i++) begin
                next_q.tx_ctl[i] = LIF_TX_CTL_RST;
                next_q.rx_ctl[i] = LIF_RX_CTL_RST;
            end
            next_q.buildout = '0;
            next_q.rdata    = LIF_RDATA_RST;
            next_q.rvalid   = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        q <= next_q;
    end

    assign cpu_rdata          = q.rdata;
    assign cpu_rvalid         = q.rvalid;
    assign tx_buildout_enable = q.buildout;

    // One transmit and one receive lane per channel
    genvar g;
    generate
        for (g = 0; g < LIF_NUM_CH; g++) begin : g_ch
            lif_lane_if u_if ();

            assign u_if.send_all_ones        =
                q.tx_ctl[g][LIF_TX_BIT_ALL_ONES];
            assign u_if.tx_clock_edge_select =
                q.tx_ctl[g][LIF_TX_BIT_EDGE];
            assign u_if.rx_clock_edge_select =
                q.rx_ctl[g][LIF_RX_BIT_EDGE];
            assign u_if.mute_on_signal_loss  =
                q.rx_ctl[g][LIF_RX_BIT_MUTE];

            lif_tx_lane u_tx (
                .lclk                (tx_line_clock_in[g]),
                .srst                (srst),
                .ctl                 (u_if),
                .tx_positive_rail_in (tx_positive_rail_in[g]),
                .tx_negative_rail_in (tx_negative_rail_in[g]),
                .tx_line_pos_out     (tx_line_pos_out[g]),
                .tx_line_neg_out     (tx_line_neg_out[g])
            );

            lif_rx_lane u_rx (
                .rclk             (rx_recovered_clock[g]),
                .srst             (srst),
                .ctl              (u_if),
                .rx_recovered_pos (rx_recovered_pos[g]),
                .rx_recovered_neg (rx_recovered_neg[g]),
                .rx_signal_loss   (rx_signal_loss[g]),
                .rx_pos_out       (rx_pos_out[g]),
                .rx_neg_out       (rx_neg_out[g])
            );
        end
    endgenerate
endmodule

// ==== tb/lif_ctrl_asserts.sv ====
`timescale 1ns/100ps
module lif_ctrl_asserts (
    input wire logic                           clk,
    input wire logic                           srst,
    input wire logic                           cpu_sel,
    input wire logic                           cpu_wr,
    input wire logic [7:0]                     cpu_addr,
    input wire logic [7:0]                     cpu_wdata,
    input wire logic [7:0]                     cpu_rdata,
    input wire logic                           cpu_rvalid,
    input wire logic [lif_pkg::LIF_NUM_CH-1:0] chan_e3_mode,
    input wire logic [lif_pkg::LIF_NUM_CH-1:0] tx_buildout_enable
);
    import lif_pkg::*;
    logic [7:0] sh0;
    logic       bo0;
    // Shadow of channel 0 transmit control
    always_ff @(posedge clk) begin
        if (srst) begin
            sh0 <= 8'h00;
        end else if (cpu_sel && cpu_wr && cpu_addr == 8'h04) begin
            sh0 <= cpu_wdata & LIF_TX_CTL_WMASK;
        end
    end
    assign bo0 = sh0[LIF_TX_BIT_BUILDOUT] && !chan_e3_mode[0];
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence rd_s;
        cpu_sel && !cpu_wr;
    endsequence
    sequence rd_at_s(logic [7:0] a);
        rd_s ##0 cpu_addr == a;
    endsequence
    rd_answer_a: assert property (rd_s |=> cpu_rvalid)
        else $error("read not answered");
    no_spurious_a: assert property (!(cpu_sel && !cpu_wr) |=> !cpu_rvalid)
        else $error("rvalid without read");
    rdata_hold_a: assert property (!cpu_rvalid |-> $stable(cpu_rdata))
        else $error("rdata moved without rvalid");
    tx_readback_a: assert property (
        rd_at_s(8'h04) |=> cpu_rdata == $past(sh0))
        else $error("tx control readback wrong");
    rx_rsvd_a: assert property (
        rd_s ##0 cpu_addr[3:0] == LIF_OFS_RX_CTL |=> cpu_rdata[7:6] == 2'b00)
        else $error("rx reserved bits set");
    unmapped_a: assert property (
        rd_s ##0 cpu_addr[7:4] inside {4'h6, 4'h7, 4'hE, 4'hF}
        |=> cpu_rdata == 8'h00) else $error("unmapped read not zero");
    buildout_a: assert property (
        tx_buildout_enable[0] == $past(bo0))
        else $error("build-out enable wrong");
    e3_gate_a: assert property (
        chan_e3_mode[0] |=> !tx_buildout_enable[0])
        else $error("build-out on in E3");
endmodule
bind lif_ctrl_top lif_ctrl_asserts u_lif_ctrl_asserts (
    .clk(clk), .srst(srst), .cpu_sel(cpu_sel), .cpu_wr(cpu_wr),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_rvalid(cpu_rvalid), .chan_e3_mode(chan_e3_mode),
    .tx_buildout_enable(tx_buildout_enable));

// ==== tb/lif_framer_model.sv ====
`timescale 1ns/100ps
module lif_framer_model (
    input  wire logic        launch_fall,
    output logic      [11:0] lclk,
    output logic      [11:0] pos,
    output logic      [11:0] neg
);
    logic [7:0] pat = 8'h01;
    logic       ck  = 1'b0;
    // Free running link clock, phase unrelated to the register clock
    initial begin
        #3.7;
        forever #62.5 ck = ~ck;
    end
    // Rails launched on the edge opposite the sampling edge
    always @(ck) begin
        if (ck != launch_fall) begin
            pat <= {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
        end
    end
    assign lclk = {12{ck}};
    assign pos  = {12{pat[0]}};
    assign neg  = {12{pat[1]}};
endmodule

// ==== tb/lif_ctrl_top_tb_top.sv ====
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
    mismatches++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module lif_ctrl_top_tb_top;
    import lif_pkg::*;
    logic        clk = 0, srst = 1, cpu_sel = 0, cpu_wr = 0, lf = 1;
    logic [7:0]  cpu_addr = 0, cpu_wdata = 0, cpu_rdata;
    logic        cpu_rvalid;
    logic [11:0] e3 = 0, los = 0, tbo, lck, tpi, tni, tpo, tno, rpo, rno;
    int          mismatches = 0, cmp_count = 0;
    logic [24:0] rows [11] = '{25'h0040000, 25'h0D50000, 25'h104FF37,
        25'h155FF3F, 25'h1D4A525, 25'h1841212, 25'h105C303, 25'h164FF00,
        25'h1E5FF00, 25'h1F4FF00, 25'h0040037};
    always #5 clk = ~clk;
    lif_framer_model u_lif_framer_model (.launch_fall(lf), .lclk(lck),
        .pos(tpi), .neg(tni));
    lif_ctrl_top u_lif_ctrl_top (.clk(clk), .srst(srst), .cpu_sel(cpu_sel),
        .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .chan_e3_mode(e3),
        .tx_buildout_enable(tbo), .tx_line_clock_in(lck),
        .tx_positive_rail_in(tpi), .tx_negative_rail_in(tni),
        .tx_line_pos_out(tpo), .tx_line_neg_out(tno),
        .rx_recovered_clock(lck), .rx_recovered_pos(tpi),
        .rx_recovered_neg(tni), .rx_signal_loss(los), .rx_pos_out(rpo),
        .rx_neg_out(rno));
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk) {cpu_sel, cpu_wr, cpu_addr, cpu_wdata} <= {2'b11, a, d};
        @(posedge clk) cpu_sel <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge clk) {cpu_sel, cpu_wr, cpu_addr} <= {2'b10, a};
        @(posedge clk) cpu_sel <= 1'b0;
        #1 `CHK("rvalid", 1'b1, cpu_rvalid)
        `CHK("rdata", e, cpu_rdata)
    endtask
    task automatic wall(input logic [3:0] o, input logic [7:0] d);
        for (int c = 0; c < 12; c++) wr({c < 6 ? 4'(c) : 4'(c + 2), o}, d);
        repeat (4) @(posedge lck[0]);
    endtask
    task automatic txchk(input logic ones);
        logic [23:0] cap;
        logic [11:0] pp;
        for (int n = 0; n < 9; n++) begin
            // Rails stand from this falling edge to the next rising edge
            @(negedge lck[0]) #1 cap = {tni, tpi};
            @(posedge lck[0]) #1 if (n > 0 && ones) begin
                `CHK("ones", 12'hFFF, tpo ^ tno)
                `CHK("alt", ~pp, tpo)
            end else if (n > 0) begin
                `CHK("rails", cap, {tno, tpo})
            end
            pp = tpo;
        end
        $display("done: tx ones=%0d lf=%0d", ones, lf);
    endtask
    task automatic rxchk(input logic inv);
        logic [23:0] v;
        for (int n = 0; n < 8; n++) begin
            if (inv) @(negedge lck[0]); else @(posedge lck[0]);
            #1 v = {rno, rpo};
            `CHK("rx_data", {tni, tpi}, v)
            if (inv) @(posedge lck[0]); else @(negedge lck[0]);
            #1 `CHK("rx_edge", v, {rno, rpo})
        end
        $display("done: rx inv=%0d", inv);
    endtask
    task automatic wrap_up;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        #1 `CHK("bo_rst", 12'h000, tbo)
        foreach (rows[i]) begin
            if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        $display("done: register table");
        wall(4'h4, 8'h03); // Long cable, build-out on
        @(posedge clk) e3 <= 12'h0F0;
        repeat (3) @(posedge clk);
        #1 `CHK("bo_e3", 12'hF0F, tbo)
        @(posedge clk) e3 <= 12'h000;
        repeat (3) @(posedge clk);
        #1 `CHK("bo", 12'hFFF, tbo)
        txchk(1'b0);
        @(posedge clk) lf <= 1'b0;
        wall(4'h4, 8'h01);
        txchk(1'b0);
        wall(4'h4, 8'h05);
        txchk(1'b1);
        wall(4'h4, 8'h00);
        txchk(1'b0);
        @(posedge clk) lf <= 1'b1;
        wall(4'h5, 8'h00);
        rxchk(1'b0);
        @(posedge clk) lf <= 1'b0;
        wall(4'h5, 8'h08);
        rxchk(1'b1);
        // Mute on loss of signal blanks the recovered rails
        wall(4'h5, 8'h0C);
        @(posedge clk) los <= 12'hFFF;
        repeat (4) @(posedge lck[0]);
        #1 `CHK("mute", 24'h000000, {rno, rpo})
        @(posedge clk) los <= 12'h000;
        $display("done: rx mute");
        // Reset in mid-run, held across three lane clock edges
        wr(8'h04, 8'h01);
        @(posedge clk) srst <= 1'b1;
        repeat (3) @(posedge lck[0]);
        #1 `CHK("lane_rst", 48'h0, {rno, rpo, tno, tpo})
        @(posedge clk) srst <= 1'b0;
        #1 `CHK("bo_rst2", 12'h000, tbo)
        rd(8'h04, 8'h00);
        rd(8'h05, 8'h00);
        $display("done: mid-run reset");
        wrap_up();
    end
endmodule
